// ==== rtl/qpm_pkg.sv ====
package qpm_pkg;
   localparam int          NPORT          = 4;
   localparam int          AW             = 16;
   localparam int          DW             = 18;
   localparam int          BYTE_W         = 9;
   // Span of the large and small arrays; mailboxes sit at the top four words
   localparam logic [15:0] SPAN_LARGE     = 16'hffff;
   localparam logic [15:0] SPAN_SMALL     = 16'h7fff;
   localparam logic [15:0] MBOX_SEL_BITS  = 16'h0003;
   localparam logic [15:0] MASK_RESET     = 16'hffff;
   localparam logic [15:0] COUNT_RESET    = 16'h0000;
   // APB map
   localparam logic [7:0]  REG_CFG        = 8'h00;
   localparam logic [7:0]  REG_STATUS     = 8'h04;
   localparam logic [7:0]  REG_MASK_BASE  = 8'h10;
   localparam logic [7:0]  REG_COUNT_BASE = 8'h20;
   localparam int          CFG_MBOX_EN    = 0;
   localparam int          CFG_SMALL      = 1;
   localparam logic [1:0]  CFG_RESET      = 2'h1;

   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic          read_not_write;
      logic          chip_select_low_active;
      logic          chip_select_high_active;
      logic          lower_byte_enable_n;
      logic          upper_byte_enable_n;
      logic          output_enable_n;
      logic          counter_load_n;
      logic          counter_advance_n;
      logic          counter_clear_n;
      logic          counter_readback_n;
      logic          mask_load_n;
   } qpm_port_in_t;

   typedef struct packed {
      logic [AW-1:0] addr_out;
      logic          addr_oe_n;
      logic [DW-1:0] rdata;
      logic          data_oe_n;
      logic          mailbox_irq_n;
      logic          counter_wrap_irq_n;
   } qpm_port_out_t;
endpackage

// ==== rtl/qpm_top.sv ====
// Local design decisions: the APB interface to the registers and the register offsets.
module qpm_top
   import qpm_pkg::*;
(
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   master_reset_n,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire qpm_pkg::qpm_port_in_t  port_in  [qpm_pkg::NPORT],
   output qpm_pkg::qpm_port_out_t      port_out [qpm_pkg::NPORT]
);
   import qpm_pkg::*;

   // Masked increment: locked bits are forced to one so the carry skips them
   function automatic logic [AW-1:0] masked_inc(input logic [AW-1:0] cnt,
                                                input logic [AW-1:0] msk);
      logic [AW-1:0] sum;
      sum = (cnt | ~msk) + 16'h0001;
      return (sum & msk) | (cnt & ~msk);
   endfunction

   function automatic logic chip_on(input qpm_port_in_t p);
      return ~p.chip_select_low_active & p.chip_select_high_active;
   endfunction

   logic                rst_n;
   logic [1:0]          cfg_q;
   logic [AW-1:0]       span;
   logic [AW-1:0]       cnt_q       [NPORT];
   logic [AW-1:0]       cnt_d       [NPORT];
   logic [AW-1:0]       mask_q      [NPORT];
   logic [AW-1:0]       eff_mask    [NPORT];
   logic [AW-1:0]       acc_addr    [NPORT];
   logic [DW-1:0]       mbox_q      [NPORT];
   logic [DW-1:0]       rdata_q     [NPORT];
   logic [AW-1:0]       addr_out_q  [NPORT];
   logic [NPORT-1:0]    addr_oe_n_q;
   logic [NPORT-1:0]    data_oe_n_q;
   logic [NPORT-1:0]    mbox_irq_n_q;
   logic [NPORT-1:0]    wrap_irq_n_q;
   logic [NPORT-1:0]    wrap_d;
   logic [NPORT-1:0]    wr;
   logic [NPORT-1:0]    rd;
   logic [NPORT-1:0]    hit;
   logic [1:0]          owner       [NPORT];
   logic [NPORT-1:0]    mb_set;
   logic [NPORT-1:0]    mb_clr;
   logic                apb_setup;
   logic                apb_access;
   logic                apb_wr;
   logic [31:0]         rd_mux;
   logic                rd_ok;
   logic                wr_ok;
   logic [31:0]         prdata_q;
   logic                err_q;

   assign rst_n = presetn & master_reset_n;

   assign span = cfg_q[CFG_SMALL] ? SPAN_SMALL : SPAN_LARGE;

   always_comb
   begin
      for (int k = 0; k < NPORT; k++)
      begin
         eff_mask[k] = mask_q[k] & span;
         if (!port_in[k].counter_clear_n)
            acc_addr[k] = COUNT_RESET;
         else if (!port_in[k].counter_load_n)
            acc_addr[k] = port_in[k].addr & span;
         else
            acc_addr[k] = cnt_q[k] & span;
         wr[k]    = chip_on(port_in[k]) & ~port_in[k].read_not_write;
         rd[k]    = chip_on(port_in[k]) & port_in[k].read_not_write;
         hit[k]   = cfg_q[CFG_MBOX_EN] & ((acc_addr[k] | MBOX_SEL_BITS) == span);
         // Port 0 owns the top word, port 3 the fourth from top
         owner[k] = ~acc_addr[k][1:0];
      end
   end

   always_comb
   begin
      for (int k = 0; k < NPORT; k++)
      begin
         wrap_d[k] = 1'b0;
         if (!port_in[k].counter_clear_n)
            cnt_d[k] = COUNT_RESET;
         else if (!port_in[k].counter_load_n)
            cnt_d[k] = port_in[k].addr & span;
         else if (!port_in[k].counter_advance_n)
         begin
            cnt_d[k]  = masked_inc(cnt_q[k], eff_mask[k]);
            wrap_d[k] = (cnt_d[k] & eff_mask[k]) == COUNT_RESET;
         end
         else
            cnt_d[k] = cnt_q[k];
      end
   end

   always_comb
   begin
      mb_set = '0;
      mb_clr = '0;
      for (int k = 0; k < NPORT; k++)
      begin
         if (wr[k] && hit[k] && owner[k] != 2'(k))
            mb_set[owner[k]] = 1'b1;
         if (rd[k] && hit[k] && owner[k] == 2'(k))
            mb_clr[k] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int k = 0; k < NPORT; k++)
            cnt_q[k] <= COUNT_RESET;
      end
      else
      begin
         for (int k = 0; k < NPORT; k++)
            cnt_q[k] <= cnt_d[k];
      end
   end

   always_ff @(posedge pclk or negedge rst_n)
   begin
      if (!rst_n)
         wrap_irq_n_q <= '1;
      else
         wrap_irq_n_q <= ~wrap_d;
   end

   always_ff @(posedge pclk or negedge rst_n)
   begin
      if (!rst_n)
         mbox_irq_n_q <= '1;
      else
      begin
         for (int t = 0; t < NPORT; t++)
         begin
            // Set wins over a clear landing in the same cycle
            if (mb_set[t])
               mbox_irq_n_q[t] <= 1'b0;
            else if (mb_clr[t])
               mbox_irq_n_q[t] <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int t = 0; t < NPORT; t++)
            mbox_q[t] <= '0;
      end
      else
      begin
         // Colliding writers: highest port index lands, contents undefined anyway
         for (int k = 0; k < NPORT; k++)
         begin
            if (wr[k] && hit[k])
            begin
               if (!port_in[k].lower_byte_enable_n)
                  mbox_q[owner[k]][BYTE_W-1:0] <= port_in[k].wdata[BYTE_W-1:0];
               if (!port_in[k].upper_byte_enable_n)
                  mbox_q[owner[k]][DW-1:BYTE_W] <= port_in[k].wdata[DW-1:BYTE_W];
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         data_oe_n_q <= '1;
         for (int k = 0; k < NPORT; k++)
            rdata_q[k] <= '0;
      end
      else
      begin
         for (int k = 0; k < NPORT; k++)
         begin
            data_oe_n_q[k] <= ~(rd[k] & ~port_in[k].output_enable_n &
                               ~(port_in[k].lower_byte_enable_n &
                                 port_in[k].upper_byte_enable_n));
            // Array outside this block; non-mailbox reads show zero here
            rdata_q[k]     <= (rd[k] && hit[k]) ? mbox_q[owner[k]] : '0;
         end
      end
   end

   always_ff @(posedge pclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         addr_oe_n_q <= '1;
         for (int k = 0; k < NPORT; k++)
            addr_out_q[k] <= '0;
      end
      else
      begin
         for (int k = 0; k < NPORT; k++)
         begin
            addr_oe_n_q[k] <= port_in[k].counter_readback_n;
            addr_out_q[k]  <= cnt_q[k];
         end
      end
   end

   always_comb
   begin
      for (int k = 0; k < NPORT; k++)
      begin
         port_out[k].addr_out           = addr_out_q[k];
         port_out[k].addr_oe_n          = addr_oe_n_q[k];
         port_out[k].rdata              = rdata_q[k];
         port_out[k].data_oe_n          = data_oe_n_q[k];
         port_out[k].mailbox_irq_n      = mbox_irq_n_q[k];
         port_out[k].counter_wrap_irq_n = wrap_irq_n_q[k];
      end
   end

   // APB slave, zero wait states; read data captured in setup
   assign apb_setup  = psel & ~penable;
   assign apb_access = psel & penable;
   assign apb_wr     = apb_access & pwrite & wr_ok;
   assign pready     = 1'b1;
   assign pslverr    = apb_access & err_q;
   assign prdata     = prdata_q;

   always_comb
   begin
      rd_mux = '0;
      rd_ok  = 1'b0;
      wr_ok  = 1'b0;
      if (paddr == REG_CFG)
      begin
         rd_mux = 32'(cfg_q);
         rd_ok  = 1'b1;
         wr_ok  = 1'b1;
      end
      else if (paddr == REG_STATUS)
      begin
         rd_mux = 32'({~wrap_irq_n_q, ~mbox_irq_n_q});
         rd_ok  = 1'b1;
      end
      else if ({paddr[7:4], 4'h0} == REG_MASK_BASE && paddr[1:0] == 2'b00)
      begin
         rd_mux = 32'(mask_q[paddr[3:2]]);
         rd_ok  = 1'b1;
         wr_ok  = 1'b1;
      end
      else if ({paddr[7:4], 4'h0} == REG_COUNT_BASE && paddr[1:0] == 2'b00)
      begin
         rd_mux = 32'(cnt_q[paddr[3:2]]);
         rd_ok  = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata_q <= '0;
         err_q    <= 1'b0;
      end
      else if (apb_setup)
      begin
         prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
         err_q    <= pwrite ? ~wr_ok : ~rd_ok;
      end
   end

   always_ff @(posedge pclk or negedge rst_n)
   begin
      if (!rst_n)
         cfg_q <= CFG_RESET;
      else if (apb_wr && paddr == REG_CFG)
         cfg_q <= pwdata[1:0];
   end

   always_ff @(posedge pclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int k = 0; k < NPORT; k++)
            mask_q[k] <= MASK_RESET;
      end
      else
      begin
         for (int k = 0; k < NPORT; k++)
         begin
            // Pin load beats a same-cycle software write
            if (!port_in[k].mask_load_n)
               mask_q[k] <= port_in[k].addr;
            else if (apb_wr && paddr != REG_CFG && paddr[3:2] == 2'(k))
               mask_q[k] <= pwdata[AW-1:0];
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!rst_n);

   for (genvar k = 0; k < NPORT; k++)
   begin : g_chk
      sequence wrap_pulse_s;
         !port_out[k].counter_wrap_irq_n ##1 port_out[k].counter_wrap_irq_n;
      endsequence

      clear_zero_a: assert property (!port_in[k].counter_clear_n |=> cnt_q[k] == 16'h0000)
         else $error("counter not zero after clear");
      load_capture_a: assert property ((port_in[k].counter_clear_n &&
            !port_in[k].counter_load_n) |=> cnt_q[k] == $past(port_in[k].addr & span))
         else $error("counter did not capture load address");
      count_hold_a: assert property ((port_in[k].counter_clear_n &&
            port_in[k].counter_load_n && port_in[k].counter_advance_n) |=> $stable(cnt_q[k]))
         else $error("counter moved without advance");
      wrap_once_a: assert property (wrap_d[k] |=> wrap_pulse_s)
         else $error("wrap interrupt not a one cycle pulse");
      wrap_cause_a: assert property ($fell(port_out[k].counter_wrap_irq_n) |->
            $past(port_in[k].counter_load_n && port_in[k].counter_clear_n) &&
            (cnt_q[k] & eff_mask[k]) == 16'h0000)
         else $error("wrap interrupt without increment to minimum");
      readback_a: assert property (!port_in[k].counter_readback_n |=>
            !port_out[k].addr_oe_n && port_out[k].addr_out == $past(cnt_q[k]))
         else $error("readback did not show counter");
      mbox_set_a: assert property (mb_set[k] |=> !port_out[k].mailbox_irq_n)
         else $error("mailbox interrupt not set");
      mbox_clear_a: assert property ((mb_clr[k] && !mb_set[k]) |=>
            port_out[k].mailbox_irq_n)
         else $error("mailbox interrupt not released");
      own_write_a: assert property ((!mb_set[k] && !mb_clr[k]) |=>
            $stable(port_out[k].mailbox_irq_n))
         else $error("mailbox interrupt changed without cause");
      mask_kept_a: assert property ((!port_in[k].counter_clear_n &&
            port_in[k].mask_load_n && !apb_wr) |=> $stable(mask_q[k]))
         else $error("mask changed on counter clear");
   end
endmodule // qpm_top

// ==== testbench/qpm_host_model.sv ====
module qpm_host_model
(
   input  wire logic             pclk,
   output logic                  master_reset_n,
   output qpm_pkg::qpm_port_in_t port_in [qpm_pkg::NPORT]
);
   timeunit 1ns;
   timeprecision 100ps;
   import qpm_pkg::*;

   // Deselected port: active-low controls high, chip off
   function automatic qpm_port_in_t idle();
      qpm_port_in_t v;
      v = '1;
      v.addr = '0;
      v.wdata = '0;
      v.chip_select_high_active = 1'b0;
      return v;
   endfunction

   // Start deselected so no stray access hits a mailbox
   initial
   begin
      master_reset_n = 1'b0;
      foreach (port_in[p])
         port_in[p] = idle();
   end

   task automatic power_up(input int n);
      repeat (n) @(posedge pclk);
      master_reset_n <= 1'b1;
   endtask

   task automatic mreset(input logic lvl);
      master_reset_n <= lvl;
   endtask

   // Caller is at a rising edge; value holds a whole cycle
   task automatic set(input int p, input qpm_port_in_t v);
      port_in[p] <= v;
   endtask
endmodule // qpm_host_model

// ==== testbench/quad_port_mailbox_and_counter_test.sv ====
module quad_port_mailbox_and_counter_test;
   timeunit 1ns;
   timeprecision 100ps;
   import qpm_pkg::*;
   logic          pclk = 1'b0;
   logic          presetn;
   logic          master_reset_n;
   logic          psel;
   logic          penable;
   logic          pwrite;
   logic [7:0]    paddr;
   logic [31:0]   pwdata;
   logic [31:0]   prdata;
   logic          pready;
   logic          pslverr;
   qpm_port_in_t  pin  [NPORT];
   qpm_port_out_t pout [NPORT];
   int            miscompares = 0;
   int            tests_run = 0;
   int            pend [NPORT];
   logic [17:0]   mbox [NPORT];

   always #2.5 pclk = ~pclk;

   qpm_host_model u_qpm_host_model
   (
      .pclk           (pclk),
      .master_reset_n (master_reset_n),
      .port_in        (pin)
   );

   qpm_top u_qpm_top
   (
      .pclk           (pclk),
      .presetn        (presetn),
      .master_reset_n (master_reset_n),
      .psel           (psel),
      .penable        (penable),
      .pwrite         (pwrite),
      .paddr          (paddr),
      .pwdata         (pwdata),
      .prdata         (prdata),
      .pready         (pready),
      .pslverr        (pslverr),
      .port_in        (pin),
      .port_out       (pout)
   );

   task automatic end_sim;
      $display("comparisons %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
      cmp("write pslverr", 32'h0, e);
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] x, input logic ee);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      cmp("prdata", x, r);
      cmp("read pslverr", ee, e);
   endtask

   function automatic qpm_port_in_t acc(input logic rd, input logic [15:0] a,
                                        input logic [17:0] d, input logic be, input logic oe);
      qpm_port_in_t v;
      v = u_qpm_host_model.idle();
      v.read_not_write = rd;
      v.addr = a;
      v.wdata = d;
      v.chip_select_low_active = 1'b0;
      v.chip_select_high_active = 1'b1;
      v.lower_byte_enable_n = !be;
      v.upper_byte_enable_n = !be;
      v.output_enable_n = !oe;
      v.counter_load_n = 1'b0;
      return v;
   endfunction

   task automatic one(input int p, input qpm_port_in_t v);
      @(posedge pclk);
      u_qpm_host_model.set(p, v);
      @(posedge pclk);
      u_qpm_host_model.set(p, u_qpm_host_model.idle());
      #1;
   endtask

   task automatic chk_irq;
      for (int p = 0; p < NPORT; p++)
         cmp("mailbox_irq_n", pend[p] == 0, pout[p].mailbox_irq_n);
   endtask

   task automatic chk_cnt(input int p, input logic [15:0] e);
      qpm_port_in_t v;
      v = u_qpm_host_model.idle();
      v.counter_readback_n = 1'b0;
      one(p, v);
      cmp("addr_oe_n", 32'h0, pout[p].addr_oe_n);
      cmp("counter", e, pout[p].addr_out);
   endtask

   // Ripple carry through unmasked bits only; masked bits keep the loaded value
   function automatic logic [15:0] bump(input logic [15:0] c, input logic [15:0] m);
      logic [15:0] r;
      int          carry;
      r = c;
      carry = 1;
      for (int b = 0; b < 16; b++)
      begin
         if (m[b] && carry == 1)
         begin
            carry = int'(r[b]);
            r[b] = ~r[b];
         end
      end
      return r;
   endfunction

   // Chip selects stay off: counter must not care
   task automatic burst(input int p, input logic [15:0] m, input logic [15:0] a, input int n);
      qpm_port_in_t v;
      logic [15:0]  c;
      int           ew;
      int           nw;
      reg_wr(REG_MASK_BASE + 8'(4 * p), {16'h0, m});
      v = u_qpm_host_model.idle();
      v.addr = a;
      v.counter_load_n = 1'b0;
      @(posedge pclk);
      u_qpm_host_model.set(p, v);
      v = u_qpm_host_model.idle();
      v.counter_advance_n = 1'b0;
      @(posedge pclk);
      u_qpm_host_model.set(p, v);
      c = a;
      ew = 0;
      nw = 0;
      for (int i = 0; i < n + 2; i++)
      begin
         @(posedge pclk);
         if (i == n - 1)
            u_qpm_host_model.set(p, u_qpm_host_model.idle());
         #1;
         nw += (pout[p].counter_wrap_irq_n === 1'b0);
         c = (i < n) ? bump(c, m) : c;
         ew += (i < n && (c & m) == 16'h0000);
      end
      cmp("wrap pulses", ew, nw);
      chk_cnt(p, c);
   endtask

   initial
   begin
      #100us;
      miscompares++;
      end_sim;
   end

   initial
   begin
      qpm_port_in_t v;
      logic [15:0]  a;
      logic [15:0]  m;
      logic [17:0]  d;
      logic         be;
      void'($urandom(14844));
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      foreach (pend[p])
         pend[p] = 0;
      u_qpm_host_model.power_up(6);
      presetn <= 1'b1;
      reg_rd(REG_CFG, 32'h1, 1'b0);
      for (int p = 0; p < NPORT; p++)
         reg_rd(REG_MASK_BASE + 8'(4 * p), 32'hffff, 1'b0);
      reg_rd(8'h0c, 32'h0, 1'b1);
      chk_irq;
      $display("test reset done");
      for (int t = 0; t < NPORT; t++)
      begin
         a = 16'hffff - 16'(t);
         mbox[t] = 18'($urandom);
         one(t, acc(1'b0, a, mbox[t], 1'b1, 1'b0));
         chk_irq;
         for (int w = 0; w < NPORT; w++)
         begin
            if (w == t)
               continue;
            d = 18'($urandom);
            be = (w != (t + 1) % NPORT);
            one(w, acc(1'b0, a, d, be, 1'b0));
            mbox[t] = be ? d : mbox[t];
            pend[t] = 1;
            chk_irq;
            one(t, acc(1'b1, a, 18'h0, 1'b0, 1'b0));
            pend[t] = 0;
            chk_irq;
            cmp("data_oe_n", 32'h1, pout[t].data_oe_n);
         end
         one(t, acc(1'b1, a, 18'h0, 1'b1, 1'b1));
         cmp("mailbox word", mbox[t], pout[t].rdata);
         cmp("data_oe_n", 32'h0, pout[t].data_oe_n);
      end
      reg_wr(REG_CFG, 32'h3);
      one(1, acc(1'b0, 16'hffff, 18'h0, 1'b0, 1'b0));
      pend[0] = 1;
      chk_irq;
      one(0, acc(1'b1, 16'h7fff, 18'h0, 1'b0, 1'b0));
      pend[0] = 0;
      chk_irq;
      reg_wr(REG_CFG, 32'h0);
      one(2, acc(1'b0, 16'hffff, 18'h0, 1'b0, 1'b0));
      chk_irq;
      reg_wr(REG_CFG, 32'h1);
      $display("test mailbox done");
      burst(1, 16'h00ff, 16'h00fd, 4);
      burst(1, 16'h5555, 16'h0007, 3);
      burst(3, 16'($urandom), 16'($urandom), 6);
      m = 16'($urandom);
      reg_wr(REG_MASK_BASE + 8'h08, {16'h0, m});
      v = u_qpm_host_model.idle();
      v.addr = 16'h1234;
      v.counter_clear_n = 1'b0;
      v.counter_load_n = 1'b0;
      v.counter_advance_n = 1'b0;
      one(2, v);
      chk_cnt(2, 16'h0000);
      v.counter_clear_n = 1'b1;
      one(2, v);
      chk_cnt(2, 16'h1234);
      reg_rd(REG_MASK_BASE + 8'h08, {16'h0, m}, 1'b0);
      v = u_qpm_host_model.idle();
      v.addr = 16'($urandom);
      v.mask_load_n = 1'b0;
      one(2, v);
      reg_rd(REG_MASK_BASE + 8'h08, {16'h0, v.addr}, 1'b0);
      $display("test counter done");
      @(posedge pclk);
      for (int w = 1; w < NPORT; w++)
         u_qpm_host_model.set(w, acc(1'b0, 16'hffff, 18'($urandom), 1'b1, 1'b0));
      @(posedge pclk);
      for (int w = 1; w < NPORT; w++)
         u_qpm_host_model.set(w, u_qpm_host_model.idle());
      #1;
      pend[0] = 1;
      chk_irq;
      reg_rd(REG_STATUS, 32'h1, 1'b0);
      // Checked before the next edge: a clocked reset would miss this
      @(posedge pclk);
      u_qpm_host_model.mreset(1'b0);
      #1;
      pend[0] = 0;
      chk_irq;
      @(posedge pclk);
      u_qpm_host_model.mreset(1'b1);
      reg_rd(REG_MASK_BASE + 8'h04, 32'hffff, 1'b0);
      reg_rd(REG_COUNT_BASE + 8'h04, 32'h0, 1'b0);
      $display("test master reset done");
      end_sim;
   end
endmodule // quad_port_mailbox_and_counter_test
